// file: rtl/lwsr_pkg.sv
// package for the late-write sync ram cycle decoder
// assumes a single clock domain, no software-visible registers
package lwsr_pkg;
    localparam int LWSR_BYTE_W = 9;
    localparam int LWSR_BYTES = 4;
    localparam int LWSR_DATA_W = LWSR_BYTE_W * LWSR_BYTES;
    localparam int LWSR_ADDR_W = 17;
    localparam logic [3:0] LWSR_ALL_BYTES_N = 4'h0;
    localparam logic [3:0] LWSR_NO_BYTES_N = 4'hf;
    localparam logic [35:0] LWSR_DOUT_RST = 36'h0_0000_0000;
    typedef enum logic [1:0] {
        LWSR_IDLE = 2'b00,
        LWSR_READ = 2'b01,
        LWSR_WRITE = 2'b11
    } lwsr_op_t;
endpackage

// file: rtl/lwsr_array.sv
// word array with per-byte write enables and combinational read data
// assumes address and enables are already aligned to the data cycle
`timescale 1ns/1ns
module lwsr_array
    import lwsr_pkg::*;
#(
    parameter int ADDR_W = 6,
    parameter int BYTE_W = LWSR_BYTE_W,
    parameter int BYTES = LWSR_BYTES
)
(
    input wire logic i_clk,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [BYTES-1:0] i_wbe,
    input wire logic [BYTE_W*BYTES-1:0] i_wdata,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [BYTE_W*BYTES-1:0] o_rdata
);
    // ****************************************
    // per-byte write lanes
    // ****************************************
    // one storage array per lane, so each lane has a single writer
    for (genvar b = 0; b < BYTES; b++)
    begin : g_lane
        logic [BYTE_W-1:0] lane_q [2**ADDR_W];
        always_ff @(posedge i_clk)
        begin
            if (i_wbe[b])
            begin
                lane_q[i_waddr] <= i_wdata[b*BYTE_W +: BYTE_W];
            end
        end
        assign o_rdata[b*BYTE_W +: BYTE_W] = lane_q[i_raddr];
    end
endmodule

// file: rtl/lwsr_top.sv
// cycle decoder of a synchronous late-write ram, 36-bit bus in four 9-bit bytes
// assumes the controller drives all control pins in the i_clk domain; dq is split
// into input, output and output enable, resolved outside
`timescale 1ns/1ns
// Summary of operation
// - read selected: drive all 36 bits next cycle, byte strobes ignored
// - only byte 0 strobe low: float bus, capture bits 0-8 next cycle
// - only byte 1 strobe low: float bus, capture bits 9-17 next cycle
// - only byte 2 strobe low: float bus, capture bits 18-26 next cycle
// - only byte 3 strobe low: float bus, capture bits 27-35 next cycle
// - all byte strobes low: float bus, write full word next cycle
// - sleep high: ignore all synchronous inputs, bus in high impedance
// - deselect or read select changes drivers only after next edge
// - write strobe low turns drivers off only after next edge
module lwsr_top
    import lwsr_pkg::*;
#(
    parameter int ADDR_W = 6
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sleep_request,
    input wire logic i_chip_select_n,
    input wire logic i_sync_write_n,
    input wire logic i_byte_strobe_0_n,
    input wire logic i_byte_strobe_1_n,
    input wire logic i_byte_strobe_2_n,
    input wire logic i_byte_strobe_3_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [LWSR_DATA_W-1:0] i_dq,
    output logic [LWSR_DATA_W-1:0] o_dq,
    output logic [LWSR_DATA_W-1:0] o_dq_oe
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rstn = rst_sync_q;

    // ****************************************
    // input synchronisers (pins from outside)
    // ****************************************
    localparam int CW = 7 + ADDR_W;
    logic [CW-1:0] pin_meta_q;
    logic [CW-1:0] pin_q;
    logic [LWSR_DATA_W-1:0] dq_meta_q;
    logic [LWSR_DATA_W-1:0] dq_q;
    wire [CW-1:0] pin_raw = {i_addr, i_byte_strobe_3_n, i_byte_strobe_2_n, i_byte_strobe_1_n,
        i_byte_strobe_0_n, i_sync_write_n, i_chip_select_n, i_sleep_request};
    // control pins, two stages each, reset to a deselect
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_meta_q <= {{ADDR_W{1'b0}}, 7'h7e};
            pin_q <= {{ADDR_W{1'b0}}, 7'h7e};
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_q <= pin_meta_q;
        end
    end

    // ****************************************
    // data bus synchroniser
    // ****************************************
    // same depth as the control path, so late write data stays one cycle behind its command
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dq_meta_q <= LWSR_DOUT_RST;
            dq_q <= LWSR_DOUT_RST;
        end
        else
        begin
            dq_meta_q <= i_dq;
            dq_q <= dq_meta_q;
        end
    end

    wire sleep = pin_q[0];
    wire cs_n = pin_q[1];
    wire we_n = pin_q[2];
    wire [3:0] bs_n = pin_q[6:3];
    wire [ADDR_W-1:0] addr = pin_q[CW-1:7];

    // ****************************************
    // cycle decode
    // ****************************************
    // sleep gates everything
    wire awake = !sleep;
    wire rd_sel = awake && !cs_n && we_n;
    wire wr_cmd = awake && !cs_n && !we_n;
    logic [3:0] wr_be;
    for (genvar b = 0; b < LWSR_BYTES; b++)
    begin : g_be
        assign wr_be[b] = wr_cmd && !bs_n[b];
    end
    wire wr_sel = |wr_be;
    wire we_kill = awake && !we_n;

    lwsr_op_t op_d;
    lwsr_op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [3:0] be_q;
    assign op_d = rd_sel ? LWSR_READ
        : (wr_sel ? LWSR_WRITE : LWSR_IDLE);

    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_q <= LWSR_IDLE;
        end
        else
        begin
            op_q <= op_d;
        end
    end

    // address held for the late data cycle
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_q <= '0;
        end
        else if (rd_sel || wr_sel)
        begin
            addr_q <= addr;
        end
    end

    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            be_q <= 4'h0;
        end
        else
        begin
            be_q <= wr_be;
        end
    end

    // ****************************************
    // storage, late write data one cycle on
    // ****************************************
    wire [3:0] array_be = (op_q == LWSR_WRITE && awake) ? be_q : 4'h0;
    logic [LWSR_DATA_W-1:0] rdata;
    lwsr_array #(
        .ADDR_W(ADDR_W)
    ) u_array (
        .i_clk(i_clk),
        .i_waddr(addr_q),
        .i_wbe(array_be),
        .i_wdata(dq_q),
        .i_raddr(addr),
        .o_rdata(rdata)
    );

    // ****************************************
    // output register and drivers
    // ****************************************
    // read after write: same address forwards pending write bytes
    logic [LWSR_DATA_W-1:0] fwd;
    always_comb
    begin
        fwd = rdata;
        for (int b = 0; b < LWSR_BYTES; b++)
        begin
            if (array_be[b] && addr_q == addr)
            begin
                fwd[b*LWSR_BYTE_W +: LWSR_BYTE_W] = dq_q[b*LWSR_BYTE_W +: LWSR_BYTE_W];
            end
        end
    end

    // drive on next cycle unless write or sleep
    wire drive_d = rd_sel && !we_kill;
    logic [LWSR_DATA_W-1:0] dout_q;
    logic [LWSR_DATA_W-1:0] oe_q;
    // read data holds until the next read
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dout_q <= LWSR_DOUT_RST;
        end
        else if (rd_sel)
        begin
            dout_q <= fwd;
        end
    end

    // enables stand for one cycle per read
    always_ff @(posedge i_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            oe_q <= '0;
        end
        else
        begin
            oe_q <= {LWSR_DATA_W{drive_d}};
        end
    end
    assign o_dq = dout_q;
    assign o_dq_oe = oe_q;
endmodule

// file: dv/lwsr_asserts.sv
// checker on the cycle decoder ports
// assumes a bind into lwsr_top, one clock
`timescale 1ns/1ns
module lwsr_asserts
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sleep_request,
    input wire logic i_chip_select_n,
    input wire logic i_sync_write_n,
    input wire logic i_byte_strobe_0_n,
    input wire logic i_byte_strobe_1_n,
    input wire logic i_byte_strobe_2_n,
    input wire logic i_byte_strobe_3_n,
    input wire logic [35:0] o_dq,
    input wire logic [35:0] o_dq_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic sel = !i_sleep_request && !i_chip_select_n;
    wire logic rd = sel && i_sync_write_n;
    wire logic wr = sel && !i_sync_write_n;
    wire logic no_be = i_byte_strobe_0_n && i_byte_strobe_1_n && i_byte_strobe_2_n
        && i_byte_strobe_3_n;
    a_read_drive: assert property (rd |-> ##3 o_dq_oe == '1)
        else $error("read not driven");
    a_write_float: assert property (wr |-> ##3 o_dq_oe == '0)
        else $error("write drove bus");
    a_abort_float: assert property (wr && no_be |-> ##3 o_dq_oe == '0)
        else $error("abort drove bus");
    a_desel_float: assert property (i_chip_select_n |-> ##3 !(|o_dq_oe))
        else $error("deselect drove bus");
    a_wkill_float: assert property (!i_sync_write_n |-> ##3 o_dq_oe == '0)
        else $error("write strobe drove bus");
    a_sleep_float: assert property (i_sleep_request |-> ##3 o_dq_oe == '0)
        else $error("sleep drove bus");
    a_oe_whole: assert property (o_dq_oe == '0 || o_dq_oe == '1)
        else $error("partial drive");
    a_dout_hold: assert property (!rd |-> ##3 $stable(o_dq))
        else $error("data changed without read");
    cover property (rd ##1 !i_chip_select_n);
    cover property (wr && no_be);
    cover property (i_sleep_request ##1 !i_sleep_request);
endmodule
bind lwsr_top lwsr_asserts chk_u (.i_clk, .i_rstn, .i_sleep_request, .i_chip_select_n,
    .i_sync_write_n, .i_byte_strobe_0_n, .i_byte_strobe_1_n, .i_byte_strobe_2_n,
    .i_byte_strobe_3_n, .o_dq, .o_dq_oe);

// file: dv/lwsr_bus_model.sv
// controller side of the shared data bus
// assumes controller drive values come from the bench
`timescale 1ns/1ns
module lwsr_bus_model
(
    input wire logic i_clk,
    input wire logic [35:0] i_ram_dq,
    input wire logic [35:0] i_ram_oe,
    input wire logic [35:0] i_ctl_dq,
    input wire logic i_ctl_oe,
    output logic [35:0] o_bus,
    output logic o_clash
);
    logic [35:0] last_q = '0;
    assign o_clash = i_ctl_oe && (|i_ram_oe);
    // released bus shows inverse of last
    assign o_bus = i_ctl_oe ? i_ctl_dq : ((i_ram_oe & i_ram_dq) | (~i_ram_oe & ~last_q));
    always @(posedge i_clk) last_q <= o_bus;
endmodule

// file: dv/testbench.sv
// self-checking bench for the cycle decoder
// assumes the bus model resolves the data bus
`timescale 1ns/1ns
module testbench;
    logic clk = 0, rstn = 0, sl = 0, cs_n = 1, we_n = 1, ctl_oe = 0, p_wr = 0, clash;
    logic [3:0] bs_n = 4'hf;
    logic [5:0] addr = '0;
    logic [35:0] ctl_dq = '0, p_d = '0, bus, rdq, roe, old;
    logic [35:0] exp_m [64];
    int error_cnt = 0, checks_done = 0, cyc_n = 0;
    initial forever #20 clk = ~clk;
    lwsr_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_sleep_request(sl), .i_chip_select_n(cs_n),
        .i_sync_write_n(we_n), .i_byte_strobe_0_n(bs_n[0]), .i_byte_strobe_1_n(bs_n[1]),
        .i_byte_strobe_2_n(bs_n[2]), .i_byte_strobe_3_n(bs_n[3]), .i_addr(addr),
        .i_dq(bus), .o_dq(rdq), .o_dq_oe(roe));
    lwsr_bus_model bus_u (.i_clk(clk), .i_ram_dq(rdq), .i_ram_oe(roe), .i_ctl_dq(ctl_dq),
        .i_ctl_oe(ctl_oe), .o_bus(bus), .o_clash(clash));
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // one bus cycle; write data follows its command
    task automatic cyc(input logic s, input logic c, input logic w, input logic [3:0] b,
        input logic [5:0] a, input logic [35:0] d);
        @(posedge clk);
        sl <= s;
        cs_n <= c;
        we_n <= w;
        bs_n <= b;
        addr <= a;
        ctl_oe <= p_wr;
        ctl_dq <= p_d;
        p_wr = !s && !c && !w;
        p_d = d;
        for (int i = 0; i < 36; i++)
            if (p_wr && !b[i / 9])
                exp_m[a][i] = d[i];
        #1;
        chk({35'h0, clash}, '0);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(0, 1, 1, 4'hf, 0, 0);
    endtask
    task automatic rd(input logic [5:0] a);
        cyc(0, 0, 1, 4'h0, a, 0);
        idle(3);
        chk(roe, '1);
        chk(rdq, exp_m[a]);
        idle(1);
        chk(roe, '0);
    endtask
    task automatic t_bytes();
        cyc(0, 0, 0, 4'h0, 6'h05, 36'h1_2345_6789);
        rd(6'h05);
        for (int n = 0; n < 4; n++)
        begin
            cyc(0, 0, 0, ~(4'h1 << n), 6'h05, {4{9'h0a5 + 9'(n)}});
            rd(6'h05);
        end
        cyc(0, 0, 0, 4'hf, 6'h05, 36'h0_0000_0000);
        rd(6'h05);
    endtask
    task automatic t_sleep();
        cyc(1, 0, 0, 4'h0, 6'h05, 36'h0_0000_0000);
        cyc(1, 0, 1, 4'h0, 6'h05, 0);
        idle(3);
        chk(roe, '0);
        rd(6'h05);
    endtask
    task automatic t_desel();
        old = exp_m[5];
        cyc(0, 0, 1, 4'h0, 6'h05, 0);
        idle(2);
        cyc(0, 0, 0, 4'h0, 6'h05, 36'h3_c3c3_c3c3);
        chk(roe, '1);
        chk(rdq, old);
        cyc(0, 1, 0, 4'h0, 6'h05, 0);
        idle(1);
        chk(roe, '0);
        rd(6'h05);
    endtask
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        idle(3);
        t_bytes();
        t_sleep();
        t_desel();
        idle(2);
        stop_test();
    end
endmodule
